//--- pkg/irf_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts for the IR event block
// Assumes: 25 MHz core clock, register index times four is the byte address
// Notes:   Definitions only
//
// Operation
// - Extended slow and medium send configured start flags
// - Four-bit code decodes to per-mode start-flag counts
// - Start-flag code ignored in basic slow, fast
// - Fast mode: sixteen preambles then long start flag
// - Event register holds eight flags, bit 7 down
// - Enable bit gates same-position event interrupt
// - Flags set even while their enable is 0
// - Transmit-empty set when FIFO and shifter empty
// - Medium/fast underrun halts transmit until enable toggles
// - Transmit-low follows count below transmit threshold
// - Receive mode forces transmit-low enable to 0
// - Receive-high on threshold or timeout in receive
// - Timeout sets line status bit; data read clears
// - Receive-high held 0 in transmit or idle
// - Slow timeout: 32 bit times without a read
// - Medium/fast timeout: 69.5 us without a read
// - Frame-end flag when last byte reaches head
// - Length-overflow when payload exceeds sixteen-bit maximum
// - CRC error flag; CRC32 fast, CRC16 otherwise
// - Full FIFO: overrun flag, byte dropped, no CRC
// - Slow modes: missing stop bit sets flag
// - Enable bits select idle, transmit or receive
`ifndef IRF_CONSTS_SVH
`define IRF_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define IRF_IDX_ENABLE 4'h1
`define IRF_IDX_FLAGS  4'h2
`define IRF_IDX_LSTAT  4'h3
`define IRF_IDX_CTRL1  4'h4
`define IRF_IDX_MODE   4'h6
`define IRF_IDX_CTRL2  4'h7
`define IRF_IDX_THR    4'h8
`define IRF_IDX_MAXL   4'hB
`define IRF_IDX_MAXH   4'hC

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IRF_B_TXE   7
`define IRF_B_TXL   6
`define IRF_B_RXH   5
`define IRF_B_EOF   4
`define IRF_B_MLE   3
`define IRF_B_CRC   2
`define IRF_B_OVR   1
`define IRF_B_STOP  0
`define IRF_B_RXEN  1
`define IRF_B_TXEN  0
`define IRF_B_SPEED 5
`define IRF_STICKY  8'h9F

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IRF_RST_BYTE 8'h00
`define IRF_RST_MAX  16'hFFFF

// ----------------------------------------------------------------
// Timing and framing
// ----------------------------------------------------------------
`define IRF_CLK_PERIOD_NS 40
`define IRF_MID_TOUT_NS   69500
`define IRF_MID_TOUT_CYC  ((`IRF_MID_TOUT_NS + `IRF_CLK_PERIOD_NS - 1) / `IRF_CLK_PERIOD_NS)
`define IRF_TOUT_BITS     32
`define IRF_PREAMBLE_SYMS 5'h10
`define IRF_FIFO_DEPTH    32

`endif

//--- pkg/irf_pkg.sv
// Purpose: Types for the IR event block
// Assumes: Used with irf_consts.svh
// Notes:   State of the block is one packed struct
package irf_pkg;

    typedef enum logic [1:0] {XFER_SLOW, XFER_EXT, XFER_MID, XFER_FAST} irf_xfer_type;
    typedef enum logic [1:0] {OP_IDLE, OP_TX, OP_RX} irf_op_type;

    typedef struct packed {
        logic [7:0]   enable;
        logic [7:0]   flags;
        logic         rxhTout;
        logic         tout;
        logic [1:0]   ctrl1;
        irf_xfer_type xfer;
        logic [2:0]   speed;
        logic [7:0]   ctrl2;
        logic [7:0]   thr;
        logic [15:0]  maxSize;
        logic [16:0]  lenCnt;
        logic         lenDone;
        logic [19:0]  toutCnt;
        logic         emptyPrev;
        logic         frameOpen;
        logic         halted;
        logic         waitReq;
        logic [7:0]   rdata;
        logic         intReq;
        logic [5:0]   sfcOut;
        logic [4:0]   preamble;
        logic         crc32;
        logic         rxAccept;
    } irf_state_type;

endpackage

//--- hdl/irf_event_flags.sv
// Purpose: Event flags, enables, receive timeout and start-flag setting of an IR link
// Assumes: Datapath supplies FIFO count and one-cycle event pulses on core_clk
// Notes:   Avalon-MM slave, one wait state per access
`timescale 1ns/1ns
`include "irf_consts.svh"

module irf_event_flags
    import irf_pkg::*;
#(
    parameter int CLK_HZ     = 25000000,
    parameter int FIFO_DEPTH = `IRF_FIFO_DEPTH
)(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [5:0]  fifoCount,
    input  wire logic        txShifterEmpty,
    input  wire logic        txFifoWrite,
    input  wire logic        txFrameEndWritten,
    input  wire logic        rxShifterDone,
    input  wire logic        rxFrameStart,
    input  wire logic        rxPayloadByte,
    input  wire logic        rxLastAtHead,
    input  wire logic        rxCrcBad,
    input  wire logic        rxStopMissing,
    input  wire logic        fifoRead,
    output logic             intReq,
    output logic [5:0]       startFlagCount,
    output logic [4:0]       preambleSymbols,
    output logic             useCrc32,
    output logic             txDataAllowed,
    output logic             rxAccept
);

    // ----------------------------------------------------------------
    // Timeout limits
    // ----------------------------------------------------------------
    localparam int LIM_2400   = (`IRF_TOUT_BITS * CLK_HZ + 2399) / 2400;
    localparam int LIM_9600   = (`IRF_TOUT_BITS * CLK_HZ + 9599) / 9600;
    localparam int LIM_19200  = (`IRF_TOUT_BITS * CLK_HZ + 19199) / 19200;
    localparam int LIM_38400  = (`IRF_TOUT_BITS * CLK_HZ + 38399) / 38400;
    localparam int LIM_57600  = (`IRF_TOUT_BITS * CLK_HZ + 57599) / 57600;
    localparam int LIM_115200 = (`IRF_TOUT_BITS * CLK_HZ + 115199) / 115200;
    localparam int LIM_MID    = `IRF_MID_TOUT_CYC;

    function automatic logic [19:0] toutLimit(input irf_xfer_type x, input logic [2:0] s);
        logic [19:0] r;
        r = 20'(LIM_MID);
        if (x == XFER_SLOW || x == XFER_EXT)
        begin
            case (s)
                3'h0:    r = 20'(LIM_2400);
                3'h1:    r = 20'(LIM_9600);
                3'h2:    r = 20'(LIM_19200);
                3'h3:    r = 20'(LIM_38400);
                3'h4:    r = 20'(LIM_57600);
                default: r = 20'(LIM_115200);
            endcase
        end
        return r;
    endfunction

    function automatic logic [5:0] thrLevel(input logic [3:0] c);
        return {1'b0, c, 1'b0};
    endfunction

    // Reserved codes and unused modes give no start flags
    function automatic logic [5:0] sfcDecode(input irf_xfer_type x, input logic [3:0] c);
        logic [5:0] r;
        r = 6'h00;
        if (x == XFER_EXT)
        begin
            case (c)
                4'h0:    r = 6'h01;
                4'h1:    r = 6'h02;
                4'h2:    r = 6'h03;
                4'h3:    r = 6'h04;
                4'h4:    r = 6'h05;
                4'h5:    r = 6'h07;
                4'h6:    r = 6'h09;
                4'h7:    r = 6'h0D;
                4'h8:    r = 6'h11;
                4'h9:    r = 6'h19;
                4'hA:    r = 6'h31;
                default: r = 6'h00;
            endcase
        end
        else if (x == XFER_MID)
        begin
            case (c)
                4'h0:    r = 6'h02;
                4'h1:    r = 6'h03;
                4'h2:    r = 6'h04;
                4'h3:    r = 6'h05;
                4'h4:    r = 6'h08;
                4'h5:    r = 6'h0C;
                4'h6:    r = 6'h10;
                4'h7:    r = 6'h18;
                default: r = 6'h00;
            endcase
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    irf_state_type s_q;
    irf_state_type s_d;
    irf_op_type    opMode;
    logic [3:0]    regIdx;
    logic          accept;
    logic          doWrite;
    logic          doRead;
    logic          txEmpty;
    logic          fastLink;
    logic          slowLink;
    logic          pushOk;
    logic          toutFire;
    logic [19:0]   limit;
    logic [7:0]    setMask;
    logic [7:0]    clrMask;
    logic [7:0]    rdMux;

    always_comb
    begin
        if (s_q.ctrl1[`IRF_B_RXEN])
            opMode = OP_RX;
        else if (s_q.ctrl1[`IRF_B_TXEN])
            opMode = OP_TX;
        else
            opMode = OP_IDLE;
    end

    assign regIdx   = avs_address[5:2];
    assign accept   = (avs_read || avs_write) && !s_q.waitReq;
    assign doWrite  = accept && avs_write && avs_byteenable[0];
    assign doRead   = accept && avs_read;
    assign txEmpty  = (fifoCount == 6'h00) && txShifterEmpty;
    assign fastLink = (s_q.xfer == XFER_MID) || (s_q.xfer == XFER_FAST);
    assign slowLink = !fastLink;
    assign pushOk   = rxShifterDone && s_q.rxAccept;
    assign limit    = toutLimit(s_q.xfer, s_q.speed);
    assign toutFire = (opMode == OP_RX) && (fifoCount != 6'h00) && !pushOk && !fifoRead
                      && (s_q.toutCnt == limit - 20'h1);

    always_comb
    begin
        case (regIdx)
            `IRF_IDX_ENABLE: rdMux = s_q.enable;
            `IRF_IDX_FLAGS:  rdMux = s_q.flags;
            `IRF_IDX_LSTAT:  rdMux = {fifoCount, 1'b0, s_q.tout};
            `IRF_IDX_CTRL1:  rdMux = {6'h00, s_q.ctrl1};
            `IRF_IDX_MODE:   rdMux = {s_q.speed, 3'h0, s_q.xfer};
            `IRF_IDX_CTRL2:  rdMux = s_q.ctrl2;
            `IRF_IDX_THR:    rdMux = s_q.thr;
            `IRF_IDX_MAXL:   rdMux = s_q.maxSize[7:0];
            `IRF_IDX_MAXH:   rdMux = s_q.maxSize[15:8];
            default:         rdMux = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        setMask = 8'h00;
        clrMask = 8'h00;

        s_d.waitReq = !((avs_read || avs_write) && s_q.waitReq);
        if ((avs_read || avs_write) && s_q.waitReq)
            s_d.rdata = avs_read ? rdMux : 8'h00;

        if (doWrite)
        begin
            case (regIdx)
                `IRF_IDX_ENABLE: s_d.enable  = avs_writedata[7:0];
                `IRF_IDX_CTRL1:  s_d.ctrl1   = avs_writedata[1:0];
                `IRF_IDX_MODE:
                begin
                    s_d.xfer  = irf_xfer_type'(avs_writedata[1:0]);
                    s_d.speed = avs_writedata[7:5];
                end
                `IRF_IDX_CTRL2:  s_d.ctrl2   = avs_writedata[7:0];
                `IRF_IDX_THR:    s_d.thr     = avs_writedata[7:0];
                `IRF_IDX_MAXL:   s_d.maxSize[7:0]  = avs_writedata[7:0];
                `IRF_IDX_MAXH:   s_d.maxSize[15:8] = avs_writedata[7:0];
                default:         s_d.enable  = s_q.enable;
            endcase
        end
        if (opMode == OP_RX)
            s_d.enable[`IRF_B_TXL] = 1'b0;

        // Only bits the reader actually saw are cleared
        if (doRead && regIdx == `IRF_IDX_FLAGS)
            clrMask = s_q.rdata & `IRF_STICKY;

        // Transmit side
        s_d.emptyPrev = txEmpty;
        if (opMode == OP_TX && txEmpty && !s_q.emptyPrev)
            setMask[`IRF_B_TXE] = 1'b1;
        if (opMode == OP_TX && txFifoWrite)
            s_d.frameOpen = 1'b1;
        if (txFrameEndWritten)
            s_d.frameOpen = 1'b0;
        if (opMode == OP_TX && fastLink && txEmpty && !s_q.emptyPrev && s_q.frameOpen)
            s_d.halted = 1'b1;
        if (!s_q.ctrl1[`IRF_B_TXEN])
            s_d.halted = 1'b0;

        // Receive timeout counter restarts on every push or read
        if (opMode != OP_RX || fifoCount == 6'h00 || pushOk || fifoRead)
            s_d.toutCnt = 20'h0;
        else if (s_q.toutCnt < limit)
            s_d.toutCnt = s_q.toutCnt + 20'h1;
        if (fifoRead)
        begin
            s_d.tout    = 1'b0;
            s_d.rxhTout = 1'b0;
        end
        if (toutFire)
        begin
            s_d.tout    = 1'b1;
            s_d.rxhTout = 1'b1;
        end
        if (opMode != OP_RX)
            s_d.rxhTout = 1'b0;

        // Receive events
        if (opMode == OP_RX)
        begin
            if (rxLastAtHead)
                setMask[`IRF_B_EOF] = 1'b1;
            if (rxCrcBad)
                setMask[`IRF_B_CRC] = 1'b1;
            if (rxShifterDone && fifoCount >= 6'(FIFO_DEPTH))
                setMask[`IRF_B_OVR] = 1'b1;
            if (rxStopMissing && slowLink)
                setMask[`IRF_B_STOP] = 1'b1;
        end
        if (rxFrameStart)
        begin
            s_d.lenCnt  = 17'h0;
            s_d.lenDone = 1'b0;
        end
        else if (opMode == OP_RX && rxPayloadByte && !s_q.lenDone)
        begin
            if (s_q.lenCnt == {1'b0, s_q.maxSize})
            begin
                setMask[`IRF_B_MLE] = 1'b1;
                s_d.lenDone = 1'b1;
            end
            else
                s_d.lenCnt = s_q.lenCnt + 17'h1;
        end

        // Set wins over a clear in the same cycle
        s_d.flags = (s_q.flags & ~clrMask) | setMask;
        s_d.flags[`IRF_B_TXL] = (opMode != OP_RX) && (fifoCount < thrLevel(s_q.thr[3:0]));
        s_d.flags[`IRF_B_RXH] = (opMode == OP_RX)
            && ((fifoCount >= thrLevel(s_q.thr[7:4])) || s_d.rxhTout);

        s_d.intReq = |(s_q.flags & s_q.enable)
                     || (s_q.tout && s_q.enable[`IRF_B_RXH]);

        s_d.sfcOut   = sfcDecode(s_q.xfer, s_q.ctrl2[3:0]);
        s_d.preamble = (s_q.xfer == XFER_FAST) ? `IRF_PREAMBLE_SYMS : 5'h00;
        s_d.crc32    = (s_q.xfer == XFER_FAST);
        s_d.rxAccept = (fifoCount < 6'(FIFO_DEPTH));
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q          <= '0;
            s_q.maxSize  <= `IRF_RST_MAX;
            s_q.waitReq  <= 1'b1;
            s_q.emptyPrev <= 1'b1;
            s_q.rxAccept <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign avs_readdata    = {24'h0, s_q.rdata};
    assign avs_waitrequest = s_q.waitReq;
    assign intReq          = s_q.intReq;
    assign startFlagCount  = s_q.sfcOut;
    assign preambleSymbols = s_q.preamble;
    assign useCrc32        = s_q.crc32;
    assign txDataAllowed   = !s_q.halted;
    assign rxAccept        = s_q.rxAccept;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence flagRead;
        doRead && regIdx == `IRF_IDX_FLAGS;
    endsequence

    irq_gate_a: assert property (intReq |-> $past(|(s_q.flags & s_q.enable)
        || (s_q.tout && s_q.enable[`IRF_B_RXH]))) else $error("interrupt without cause");
    txl_mask_a: assert property (opMode == OP_RX |=> !s_q.enable[`IRF_B_TXL])
        else $error("transmit-low enable not forced off");
    rxh_idle_a: assert property (opMode != OP_RX |=> !s_q.flags[`IRF_B_RXH])
        else $error("receive-high outside receive");
    ovr_set_a: assert property (opMode == OP_RX && rxShifterDone
        && fifoCount >= 6'(FIFO_DEPTH) |=> s_q.flags[`IRF_B_OVR] && !s_q.rxAccept)
        else $error("overrun not flagged");
    read_clear_a: assert property (flagRead ##0 (s_q.rdata[`IRF_B_EOF] && !rxLastAtHead)
        |=> !s_q.flags[`IRF_B_EOF]) else $error("frame-end not cleared by read");
    tout_fire_a: assert property (toutFire |=> s_q.tout && s_q.flags[`IRF_B_RXH])
        else $error("timeout not raised");
    stop_mode_a: assert property (fastLink && !s_q.flags[`IRF_B_STOP]
        |=> !s_q.flags[`IRF_B_STOP]) else $error("stop-bit flag in fast link");
    fast_frame_a: assert property (s_q.xfer == XFER_FAST [*2]
        |-> startFlagCount == 6'h00 && preambleSymbols == 5'h10) else $error("fast framing");
    wait_cycle_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing");
    halt_hold_a: assert property (!txDataAllowed && s_q.ctrl1[`IRF_B_TXEN]
        |=> !txDataAllowed) else $error("halt released without toggle");

endmodule // irf_event_flags

//--- test/irf_ir_partner.sv
// Purpose: Far-side stand-in that issues one-cycle link and FIFO event pulses
// Assumes: Bench selects the event and strobes evGo for one cycle
// Notes:   Pulses are registered, so they stand exactly one cycle
`timescale 1ns/1ns

module irf_ir_partner (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       evGo,
    input  wire logic [3:0] evSel,
    output logic            txFifoWrite,
    output logic            txFrameEndWritten,
    output logic            rxShifterDone,
    output logic            rxFrameStart,
    output logic            rxPayloadByte,
    output logic            rxLastAtHead,
    output logic            rxCrcBad,
    output logic            rxStopMissing,
    output logic            fifoRead
);
    logic [8:0] pulse_q;

    // One event at a time; a host read of the FIFO is a pulse too
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            pulse_q <= 9'h000;
        else
            pulse_q <= evGo ? (9'h001 << evSel) : 9'h000;
    end

    assign {fifoRead, rxStopMissing, rxCrcBad, rxLastAtHead, rxPayloadByte,
            rxFrameStart, rxShifterDone, txFrameEndWritten, txFifoWrite} = pulse_q;
endmodule // irf_ir_partner

//--- test/tb.sv
// Purpose: Self-checking bench for the IR event flag block
// Assumes: Avalon-MM master with one request in flight
// Notes:   Reads are checked by a watcher against a queue of expectations
`timescale 1ns/1ns
`include "irf_consts.svh"

module tb
    import irf_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [5:0]  fifoCount = 6'h00;
    logic        txShifterEmpty = 1'b1;
    logic        evGo = 1'b0;
    logic [3:0]  evSel = 4'h0;
    logic        txFifoWrite, txFrameEndWritten, rxShifterDone, rxFrameStart;
    logic        rxPayloadByte, rxLastAtHead, rxCrcBad, rxStopMissing, fifoRead;
    logic        intReq, useCrc32, txDataAllowed, rxAccept;
    logic [5:0]  startFlagCount;
    logic [4:0]  preambleSymbols;
    logic [5:0]  sfcE;
    logic [7:0]  expQ[$];
    logic [31:0] seed = 32'h00009FB2;
    logic [5:0]  extTab[11] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h07,
                                6'h09, 6'h0D, 6'h11, 6'h19, 6'h31};
    logic [5:0]  midTab[8] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h08, 6'h0C, 6'h10, 6'h18};
    int          miscompares = 0;
    int          checks = 0;
    int          cyc = 0;

    // Low clock figure shortens the 115200-baud slow-mode timeout to a few dozen cycles
    irf_event_flags #(.CLK_HZ(240000)) dut (.core_clk(core_clk), .nrst(nrst),
        .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .fifoCount(fifoCount),
        .txShifterEmpty(txShifterEmpty), .txFifoWrite(txFifoWrite),
        .txFrameEndWritten(txFrameEndWritten), .rxShifterDone(rxShifterDone),
        .rxFrameStart(rxFrameStart), .rxPayloadByte(rxPayloadByte),
        .rxLastAtHead(rxLastAtHead), .rxCrcBad(rxCrcBad), .rxStopMissing(rxStopMissing),
        .fifoRead(fifoRead), .intReq(intReq), .startFlagCount(startFlagCount),
        .preambleSymbols(preambleSymbols), .useCrc32(useCrc32),
        .txDataAllowed(txDataAllowed), .rxAccept(rxAccept));

    irf_ir_partner partner (.core_clk(core_clk), .nrst(nrst), .evGo(evGo), .evSel(evSel),
        .txFifoWrite(txFifoWrite), .txFrameEndWritten(txFrameEndWritten),
        .rxShifterDone(rxShifterDone), .rxFrameStart(rxFrameStart),
        .rxPayloadByte(rxPayloadByte), .rxLastAtHead(rxLastAtHead), .rxCrcBad(rxCrcBad),
        .rxStopMissing(rxStopMissing), .fifoRead(fifoRead));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] r;
        r = v ^ (v << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction

    task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= {24'h000000, d};
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [3:0] idx, input logic [7:0] e);
        expQ.push_back(e);
        bus(1'b0, idx, 8'h00);
    endtask

    task automatic ev(input logic [3:0] s);
        @(posedge core_clk);
        evSel <= s;
        evGo <= 1'b1;
        @(posedge core_clk) evGo <= 1'b0;
        tick(3);
    endtask

    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, watcher, timeout
    // ----------------------------------------------------------------
    initial forever #20 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        if (avs_read && avs_waitrequest === 1'b0)
            chk("readdata", avs_readdata[7:0], expQ.pop_front());
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            close_out;
        end
    end

    initial
    begin
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        rd(`IRF_IDX_ENABLE, 8'h00);
        rd(`IRF_IDX_FLAGS, 8'h00);
        rd(`IRF_IDX_MAXL, 8'hFF);
        rd(`IRF_IDX_MAXH, 8'hFF);
        wr(`IRF_IDX_LSTAT, 8'h5A);
        rd(`IRF_IDX_LSTAT, 8'h00);
        rd(4'hF, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            seed = xs(seed);
            wr(`IRF_IDX_ENABLE, seed[7:0]);
            rd(`IRF_IDX_ENABLE, seed[7:0]);
        end
        wr(`IRF_IDX_ENABLE, 8'h00);
        // Transmit empty and transmit low
        wr(`IRF_IDX_THR, 8'h44);
        @(posedge core_clk) txShifterEmpty <= 1'b0;
        wr(`IRF_IDX_CTRL1, 8'h01);
        @(posedge core_clk) txShifterEmpty <= 1'b1;
        tick(3);
        rd(`IRF_IDX_FLAGS, 8'hC0);
        rd(`IRF_IDX_FLAGS, 8'h40);
        chk("intReq", {7'h00, intReq}, 8'h00);
        @(posedge core_clk) fifoCount <= 6'h08;
        rd(`IRF_IDX_FLAGS, 8'h00);
        @(posedge core_clk) fifoCount <= 6'h07;
        rd(`IRF_IDX_FLAGS, 8'h40);
        // Receive mode gating
        wr(`IRF_IDX_ENABLE, 8'hFF);
        wr(`IRF_IDX_CTRL1, 8'h03);
        rd(`IRF_IDX_ENABLE, 8'hBF);
        rd(`IRF_IDX_FLAGS, 8'h00);
        @(posedge core_clk) fifoCount <= 6'h08;
        rd(`IRF_IDX_FLAGS, 8'h20);
        wr(`IRF_IDX_CTRL1, 8'h00);
        rd(`IRF_IDX_FLAGS, 8'h00);
        // Sticky receive events
        wr(`IRF_IDX_ENABLE, 8'h00);
        wr(`IRF_IDX_MODE, 8'h01);
        wr(`IRF_IDX_CTRL1, 8'h02);
        @(posedge core_clk) fifoCount <= 6'h00;
        ev(4'h6);
        ev(4'h7);
        ev(4'h5);
        @(posedge core_clk) fifoCount <= 6'h20;
        tick(2);
        chk("rxAccept", {7'h00, rxAccept}, 8'h00);
        ev(4'h2);
        @(posedge core_clk) fifoCount <= 6'h00;
        tick(3);
        chk("intReq", {7'h00, intReq}, 8'h00);
        chk("rxAccept", {7'h00, rxAccept}, 8'h01);
        wr(`IRF_IDX_ENABLE, 8'h04);
        tick(3);
        chk("intReq", {7'h00, intReq}, 8'h01);
        rd(`IRF_IDX_FLAGS, 8'h17);
        tick(3);
        chk("intReq", {7'h00, intReq}, 8'h00);
        rd(`IRF_IDX_FLAGS, 8'h00);
        wr(`IRF_IDX_MAXL, 8'h02);
        wr(`IRF_IDX_MAXH, 8'h00);
        ev(4'h3);
        ev(4'h4);
        ev(4'h4);
        rd(`IRF_IDX_FLAGS, 8'h00);
        ev(4'h4);
        rd(`IRF_IDX_FLAGS, 8'h08);
        wr(`IRF_IDX_MODE, 8'h02);
        ev(4'h7);
        rd(`IRF_IDX_FLAGS, 8'h00);
        wr(`IRF_IDX_CTRL1, 8'h00);
        // Start flag decoding per transfer mode
        for (int m = 0; m < 4; m++)
        begin
            wr(`IRF_IDX_MODE, m[7:0]);
            for (int c = 0; c < 16; c++)
            begin
                wr(`IRF_IDX_CTRL2, c[7:0]);
                tick(3);
                sfcE = (m == 1 && c < 11) ? extTab[c] : (m == 2 && c < 8) ? midTab[c] : 6'h00;
                chk("startFlags", {2'h0, startFlagCount}, {2'h0, sfcE});
            end
            chk("preamble", {3'h0, preambleSymbols}, (m == 3) ? 8'h10 : 8'h00);
            chk("crc32", {7'h00, useCrc32}, (m == 3) ? 8'h01 : 8'h00);
        end
        // Medium speed receive timeout, 1738 cycles; stop-bit enable kept off
        wr(`IRF_IDX_MODE, 8'h02);
        wr(`IRF_IDX_THR, 8'hF0);
        wr(`IRF_IDX_ENABLE, 8'h20);
        wr(`IRF_IDX_CTRL1, 8'h02);
        @(posedge core_clk) fifoCount <= 6'h01;
        tick(1733);
        rd(`IRF_IDX_LSTAT, 8'h04);
        tick(1);
        rd(`IRF_IDX_LSTAT, 8'h05);
        rd(`IRF_IDX_FLAGS, 8'h20);
        chk("intReq", {7'h00, intReq}, 8'h01);
        ev(4'h8);
        rd(`IRF_IDX_LSTAT, 8'h04);
        rd(`IRF_IDX_FLAGS, 8'h00);
        chk("intReq", {7'h00, intReq}, 8'h00);
        // Medium speed underrun halts transmit
        wr(`IRF_IDX_CTRL1, 8'h00);
        @(posedge core_clk) txShifterEmpty <= 1'b0;
        wr(`IRF_IDX_CTRL1, 8'h01);
        ev(4'h0);
        chk("txAllowed", {7'h00, txDataAllowed}, 8'h01);
        @(posedge core_clk) fifoCount <= 6'h00;
        txShifterEmpty <= 1'b1;
        tick(3);
        chk("txAllowed", {7'h00, txDataAllowed}, 8'h00);
        wr(`IRF_IDX_CTRL1, 8'h00);
        tick(3);
        chk("txAllowed", {7'h00, txDataAllowed}, 8'h01);
        // Extended slow timeout at 115200 baud: 32 bit times are 67 cycles here
        wr(`IRF_IDX_MODE, 8'hA1);
        wr(`IRF_IDX_CTRL1, 8'h02);
        @(posedge core_clk) fifoCount <= 6'h01;
        tick(62);
        rd(`IRF_IDX_LSTAT, 8'h04);
        tick(1);
        rd(`IRF_IDX_LSTAT, 8'h05);
        wr(`IRF_IDX_CTRL1, 8'h00);
        tick(4);
        close_out;
    end
endmodule // tb
